// *** hdl/usi_pkg.sv ***
// Constants and event carrier for the USB engine register interface
package usi_pkg;

   // Register locations in data-memory bank 1
   localparam logic [7:0] USI_ADDR_RSV_LO = 8'h40;
   localparam logic [7:0] USI_ADDR_DIR = 8'h41;
   localparam logic [7:0] USI_ADDR_DEVADDR = 8'h42;
   localparam logic [7:0] USI_ADDR_HALT = 8'h43;
   localparam logic [7:0] USI_ADDR_ACCESS = 8'h44;
   localparam logic [7:0] USI_ADDR_STATUS = 8'h45;
   localparam logic [7:0] USI_ADDR_BUFCMD = 8'h46;
   localparam logic [7:0] USI_ADDR_EP0BUF = 8'h48;
   localparam logic [7:0] USI_ADDR_EP1BUF = 8'h49;
   localparam logic [7:0] USI_ADDR_RSV_MID = 8'h4a;
   localparam logic [7:0] USI_ADDR_RSV_HI = 8'h4f;

   // Reset values
   localparam logic [7:0] USI_DEVADDR_RST = 8'h00;
   localparam logic [1:0] USI_DIR_RST = 2'h3;
   localparam logic [1:0] USI_HALT_RST = 2'h0;
   localparam logic [1:0] USI_ACCESS_RST = 2'h0;
   localparam logic USI_EOT_RST = 1'b1;

   // Endpoint count and device address field
   localparam int USI_NUM_EP = 2;
   localparam int USI_WAKE_BIT = 0;
   localparam int USI_ADDR_LSB = 1;
   localparam int USI_ADDR_W = 7;

   // Engine status field positions
   localparam int USI_ST_ADRSET = 0;
   localparam int USI_ST_F0ERR = 1;
   localparam int USI_ST_OUT = 2;
   localparam int USI_ST_IN = 3;
   localparam int USI_ST_NAK = 4;
   localparam int USI_ST_CRC = 5;
   localparam int USI_ST_EOT = 6;
   localparam int USI_ST_MNI = 7;

   // Event pulses and levels from the serial engine
   typedef struct packed {
      logic setup_ok;
      logic in_token;
      logic out_token;
      logic out_nonzero;
      logic in_acked;
      logic nak_sent;
      logic crc_err;
      logic ep0_buffer_error;
      logic [1:0] ep_hit;
      logic eot_level;
   } usi_sie_ev_s;

endpackage : usi_pkg

// *** hdl/usi_regs.sv ***
// Firmware register file between the microcontroller and the USB engine
`timescale 1ns/1ps
module usi_regs
   import usi_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic mem_bank1,
   input wire logic [7:0] mem_addr,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_rd,
   output logic [7:0] mem_rdata,
   input wire usi_sie_ev_s sie_ev,
   output logic [USI_ADDR_W-1:0] dev_addr,
   output logic remote_wakeup,
   output logic [USI_NUM_EP-1:0] ep_dir_in,
   output logic [USI_NUM_EP-1:0] ep_halt,
   output logic nak_irq
);

   logic [7:0] addr_reg_q;
   logic [USI_ADDR_W-1:0] dev_addr_q;
   logic [USI_NUM_EP-1:0] dir_q;
   logic [USI_NUM_EP-1:0] halt_q;
   logic [USI_NUM_EP-1:0] acc_q;
   logic adrset_q;
   logic f0err_q;
   logic out_q;
   logic in_q;
   logic nak_q;
   logic crc_q;
   logic eot_q;
   logic mni_q;
   logic nak_irq_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [7:0] status;
   logic wr_dir;
   logic wr_addr;
   logic wr_halt;
   logic wr_stat;
   logic rd_acc;

   // Decode only inside bank 1; reserved slots match nothing
   assign wr_dir = mem_wr & mem_bank1 & (mem_addr == USI_ADDR_DIR);
   assign wr_addr = mem_wr & mem_bank1 & (mem_addr == USI_ADDR_DEVADDR);
   assign wr_halt = mem_wr & mem_bank1 & (mem_addr == USI_ADDR_HALT);
   assign wr_stat = mem_wr & mem_bank1 & (mem_addr == USI_ADDR_STATUS);
   assign rd_acc = mem_rd & mem_bank1 & (mem_addr == USI_ADDR_ACCESS);

   // Address and wake-up register as firmware wrote it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         addr_reg_q <= USI_DEVADDR_RST;
      end else if (wr_addr) begin
         addr_reg_q <= mem_wdata;
      end
   end

   // Address the engine answers to
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         dev_addr_q <= USI_DEVADDR_RST[USI_ADDR_LSB +: USI_ADDR_W];
      end else if (wr_addr && !adrset_q) begin
         dev_addr_q <= mem_wdata[USI_ADDR_LSB +: USI_ADDR_W];
      end else if (adrset_q && sie_ev.in_acked) begin
         dev_addr_q <= addr_reg_q[USI_ADDR_LSB +: USI_ADDR_W];
      end
   end

   // Deferred update bit; a firmware set beats the engine's clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         adrset_q <= 1'b0;
      end else if (wr_stat) begin
         adrset_q <= mem_wdata[USI_ST_ADRSET];
      end else if (adrset_q && sie_ev.in_acked) begin
         adrset_q <= 1'b0;
      end
   end

   // Per-endpoint bitmaps
   genvar ep;
   generate
      for (ep = 0; ep < USI_NUM_EP; ep++) begin : g_ep
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               dir_q[ep] <= USI_DIR_RST[ep];
            end else if (wr_dir) begin
               dir_q[ep] <= mem_wdata[ep];
            end
         end
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               halt_q[ep] <= USI_HALT_RST[ep];
            end else if (wr_halt) begin
               halt_q[ep] <= mem_wdata[ep];
            end
         end
         // Cleared by a firmware read; a hit in that cycle still lands
         always_ff @(posedge core_clk) begin
            if (!rst_n) begin
               acc_q[ep] <= USI_ACCESS_RST[ep];
            end else if (sie_ev.ep_hit[ep]) begin
               acc_q[ep] <= 1'b1;
            end else if (rd_acc) begin
               acc_q[ep] <= 1'b0;
            end
         end
      end
   endgenerate

   // Buffer error: writing 0 clears, engine set wins
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         f0err_q <= 1'b0;
      end else if (sie_ev.ep0_buffer_error) begin
         f0err_q <= 1'b1;
      end else if (wr_stat && !mem_wdata[USI_ST_F0ERR]) begin
         f0err_q <= 1'b0;
      end
   end

   // OUT data waiting
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_q <= 1'b0;
      end else if (sie_ev.out_token && sie_ev.out_nonzero) begin
         out_q <= 1'b1;
      end else if (sie_ev.setup_ok) begin
         out_q <= 1'b0;
      end else if (wr_stat && !mem_wdata[USI_ST_OUT]) begin
         out_q <= 1'b0;
      end
   end

   // Kind of the latest token; any other token drops it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         in_q <= 1'b0;
      end else if (sie_ev.in_token) begin
         in_q <= 1'b1;
      end else if (sie_ev.out_token || sie_ev.setup_ok) begin
         in_q <= 1'b0;
      end
   end

   // NAK report, held until the next token arrives
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         nak_q <= 1'b0;
      end else if (sie_ev.nak_sent) begin
         nak_q <= 1'b1;
      end else if (sie_ev.in_token || sie_ev.out_token
                   || sie_ev.setup_ok) begin
         nak_q <= 1'b0;
      end
   end

   // Checksum error, sticky until firmware writes 0
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         crc_q <= 1'b0;
      end else if (sie_ev.crc_err) begin
         crc_q <= 1'b1;
      end else if (wr_stat && !mem_wdata[USI_ST_CRC]) begin
         crc_q <= 1'b0;
      end
   end

   // Engine level, same clock, so one stage only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         eot_q <= USI_EOT_RST;
      end else begin
         eot_q <= sie_ev.eot_level;
      end
   end

   // NAK interrupt mask and the gated interrupt pulse
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mni_q <= 1'b0;
      end else if (wr_stat) begin
         mni_q <= mem_wdata[USI_ST_MNI];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         nak_irq_q <= 1'b0;
      end else begin
         nak_irq_q <= sie_ev.nak_sent & ~mni_q;
      end
   end

   always_comb begin
      status = 8'h00;
      status[USI_ST_ADRSET] = adrset_q;
      status[USI_ST_F0ERR] = f0err_q;
      status[USI_ST_OUT] = out_q;
      status[USI_ST_IN] = in_q;
      status[USI_ST_NAK] = nak_q;
      status[USI_ST_CRC] = crc_q;
      status[USI_ST_EOT] = eot_q;
      status[USI_ST_MNI] = mni_q;
   end

   // Read mux; buffer command and buffer ports live elsewhere, read 0 here
   always_comb begin
      rdata_d = 8'h00;
      if (mem_bank1) begin
         case (mem_addr)
            USI_ADDR_DIR: rdata_d = {6'h00, dir_q};
            USI_ADDR_DEVADDR: rdata_d = addr_reg_q;
            USI_ADDR_HALT: rdata_d = {6'h00, halt_q};
            USI_ADDR_ACCESS: rdata_d = {6'h00, acc_q};
            USI_ADDR_STATUS: rdata_d = status;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (mem_rd) begin
         rdata_q <= rdata_d;
      end
   end

   assign mem_rdata = rdata_q;
   assign dev_addr = dev_addr_q;
   assign remote_wakeup = addr_reg_q[USI_WAKE_BIT];
   assign ep_dir_in = dir_q;
   assign ep_halt = halt_q;
   assign nak_irq = nak_irq_q;

   // Checks
   AST_RSV_READ_ZERO: assert property (@(posedge core_clk)
      disable iff (!rst_n) mem_rd && mem_bank1
      && (mem_addr == USI_ADDR_RSV_LO || mem_addr == USI_ADDR_RSV_MID
          || mem_addr == USI_ADDR_RSV_HI) |=> mem_rdata == 8'h00)
      else $error("Reserved slot read nonzero");

   AST_ADDR_RESET: assert property (@(posedge core_clk)
      !rst_n |=> dev_addr == 7'h00 && addr_reg_q == 8'h00)
      else $error("Address not zero after reset");

   AST_WAKE_BIT: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      wr_addr |=> remote_wakeup == $past(mem_wdata[0]))
      else $error("Wake-up bit not taken from bit 0");

   AST_DIR_RESET: assert property (@(posedge core_clk)
      !rst_n |=> ep_dir_in == 2'b11)
      else $error("Endpoints not IN after reset");

   AST_ACC_ONLY_ON_HIT: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      !acc_q[0] && !sie_ev.ep_hit[0] |=> !acc_q[0])
      else $error("Access bit set without host access");

   AST_ACC_SET: assert property (@(posedge core_clk)
      disable iff (!rst_n) sie_ev.ep_hit[1] |=> acc_q[1])
      else $error("Access bit missed host access");

   AST_DEFER_LOAD: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      adrset_q && sie_ev.in_acked && !wr_stat && !wr_addr
      |=> dev_addr == $past(addr_reg_q[7:1]) && !adrset_q)
      else $error("Deferred address not loaded after IN");

   AST_DEFER_HOLD: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      adrset_q && !sie_ev.in_acked |=> $stable(dev_addr))
      else $error("Address changed before IN completed");

   AST_IMMEDIATE: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      wr_addr && !adrset_q |=> dev_addr == $past(mem_wdata[7:1]))
      else $error("Address not adopted at once");

   AST_F0_STICKY: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      sie_ev.ep0_buffer_error ##1 !(wr_stat && !mem_wdata[1])[*2] |=> f0err_q)
      else $error("Buffer error flag lost");

   AST_OUT_SET: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      sie_ev.out_token && sie_ev.out_nonzero |=> out_q)
      else $error("OUT flag not set");

   AST_OUT_SETUP_CLR: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      sie_ev.setup_ok && !sie_ev.out_token |=> !out_q)
      else $error("OUT flag survived SETUP");

   AST_IN_FLAG: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      sie_ev.in_token |=> status[USI_ST_IN])
      else $error("IN token not reported");

   AST_NAK_FLAG: assert property (@(posedge core_clk)
      disable iff (!rst_n) sie_ev.nak_sent |=> nak_q)
      else $error("NAK not reported");

   AST_CRC_STICKY: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      crc_q && !(wr_stat && !mem_wdata[5]) |=> crc_q)
      else $error("Checksum flag cleared without firmware");

   AST_EOT_READ: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      mem_rd && mem_bank1 && mem_addr == USI_ADDR_STATUS
      && $past(rst_n)
      |=> mem_rdata[USI_ST_EOT] == $past(sie_ev.eot_level, 2))
      else $error("End-of-transfer flag misread");

   AST_NAK_MASK: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      sie_ev.nak_sent |=> nak_irq == !$past(mni_q))
      else $error("NAK interrupt mask wrong");

   AST_RSV_BITS: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      mem_rd && mem_bank1 && (mem_addr == USI_ADDR_DIR
      || mem_addr == USI_ADDR_HALT || mem_addr == USI_ADDR_ACCESS)
      |=> mem_rdata[7:2] == 6'h00)
      else $error("Reserved bitmap bits nonzero");

   COV_DEFER: cover property (@(posedge core_clk) disable iff (!rst_n)
      adrset_q ##1 sie_ev.in_acked ##1 !adrset_q);
   COV_OUT_SETUP: cover property (@(posedge core_clk) disable iff (!rst_n)
      out_q ##1 sie_ev.setup_ok ##1 !out_q);
   COV_NAK_IRQ: cover property (@(posedge core_clk) disable iff (!rst_n)
      sie_ev.nak_sent ##1 nak_irq);
   COV_CRC_CLR: cover property (@(posedge core_clk) disable iff (!rst_n)
      crc_q ##1 wr_stat ##1 !crc_q);

endmodule : usi_regs

// *** testbench/usi_sie_model.sv ***
// Behavioural serial engine that turns host traffic into event pulses
`timescale 1ns/1ps
module usi_sie_model
   import usi_pkg::*;
(
   input wire logic core_clk,
   output usi_sie_ev_s sie_ev
);
   initial begin
      sie_ev = {10'h000, 1'b1};
   end

   // Pulse bits in struct order, end-of-transfer level kept as is
   task automatic send(input logic [9:0] bits);
      @(negedge core_clk);
      sie_ev <= {bits, sie_ev.eot_level};
      @(negedge core_clk);
      sie_ev <= {10'h000, sie_ev.eot_level};
   endtask : send

   // Line fault drops the level until the host recovers it
   task automatic set_eot(input logic lvl);
      @(negedge core_clk);
      sie_ev.eot_level <= lvl;
   endtask : set_eot
endmodule : usi_sie_model

// *** testbench/tb_usi_regs.sv ***
// Self-checking bench for the engine register interface
`timescale 1ns/1ps
module tb_usi_regs
   import usi_pkg::*;
;
   localparam logic [9:0] EV_SETUP = 10'h200;
   localparam logic [9:0] EV_IN = 10'h100;
   localparam logic [9:0] EV_OUTNZ = 10'h0c0;
   localparam logic [9:0] EV_ACK = 10'h020;
   localparam logic [9:0] EV_NAK = 10'h010;
   localparam logic [9:0] EV_CRC = 10'h008;
   localparam logic [9:0] EV_F0 = 10'h004;
   localparam logic [9:0] EV_EP1 = 10'h002;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic mem_bank1 = 1'b0;
   logic [7:0] mem_addr = 8'h00;
   logic mem_wr = 1'b0;
   logic [7:0] mem_wdata = 8'h00;
   logic mem_rd = 1'b0;
   logic [7:0] mem_rdata;
   usi_sie_ev_s sie_ev;
   logic [USI_ADDR_W-1:0] dev_addr;
   logic remote_wakeup;
   logic [USI_NUM_EP-1:0] ep_dir_in;
   logic [USI_NUM_EP-1:0] ep_halt;
   logic nak_irq;
   int err_count = 0;
   int cmp_count = 0;

   always #5 core_clk = ~core_clk;

   usi_regs i_dut (.core_clk(core_clk), .rst_n(rst_n),
      .mem_bank1(mem_bank1), .mem_addr(mem_addr), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
      .sie_ev(sie_ev), .dev_addr(dev_addr),
      .remote_wakeup(remote_wakeup), .ep_dir_in(ep_dir_in),
      .ep_halt(ep_halt), .nak_irq(nak_irq));
   usi_sie_model i_sie (.core_clk(core_clk), .sie_ev(sie_ev));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   // Released address and data lines show the inverse, not a stale copy
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic b);
      @(negedge core_clk);
      mem_bank1 <= b;
      mem_addr <= a;
      mem_wdata <= d;
      mem_wr <= 1'b1;
      @(negedge core_clk);
      mem_wr <= 1'b0;
      mem_addr <= ~a;
      mem_wdata <= ~d;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      mem_bank1 <= 1'b1;
      mem_addr <= a;
      mem_rd <= 1'b1;
      @(negedge core_clk);
      mem_rd <= 1'b0;
      mem_addr <= ~a;
      chk(mem_rdata, exp);
   endtask : rd_chk

   task automatic t_reset;
      rd_chk(USI_ADDR_DIR, 8'h03);
      rd_chk(USI_ADDR_DEVADDR, 8'h00);
      rd_chk(USI_ADDR_HALT, 8'h00);
      rd_chk(USI_ADDR_ACCESS, 8'h00);
      rd_chk(USI_ADDR_STATUS, 8'h40);
      rd_chk(USI_ADDR_RSV_LO, 8'h00);
      rd_chk(USI_ADDR_RSV_MID, 8'h00);
      rd_chk(USI_ADDR_RSV_HI, 8'h00);
      chk({6'h00, ep_dir_in}, 8'h03);
   endtask : t_reset

   task automatic t_bitmaps;
      wr(USI_ADDR_DIR, 8'h00, 1'b0);
      rd_chk(USI_ADDR_DIR, 8'h03);
      wr(USI_ADDR_DIR, 8'hfe, 1'b1);
      rd_chk(USI_ADDR_DIR, 8'h02);
      chk({6'h00, ep_dir_in}, 8'h02);
      wr(USI_ADDR_HALT, 8'hfd, 1'b1);
      rd_chk(USI_ADDR_HALT, 8'h01);
      chk({6'h00, ep_halt}, 8'h01);
      wr(USI_ADDR_ACCESS, 8'hff, 1'b1);
      rd_chk(USI_ADDR_ACCESS, 8'h00);
      wr(USI_ADDR_RSV_MID, 8'hff, 1'b1);
      rd_chk(USI_ADDR_RSV_MID, 8'h00);
   endtask : t_bitmaps

   task automatic t_address;
      wr(USI_ADDR_DEVADDR, 8'h0b, 1'b1);
      chk({1'b0, dev_addr}, 8'h05);
      chk({7'h00, remote_wakeup}, 8'h01);
      rd_chk(USI_ADDR_DEVADDR, 8'h0b);
      // Deferred load waits for the host to take IN data
      wr(USI_ADDR_STATUS, 8'h01, 1'b1);
      wr(USI_ADDR_DEVADDR, 8'h14, 1'b1);
      chk({1'b0, dev_addr}, 8'h05);
      i_sie.send(EV_ACK);
      chk({1'b0, dev_addr}, 8'h0a);
      rd_chk(USI_ADDR_STATUS, 8'h40);
      // Deferred bit withdrawn: host IN must not load the pending value
      wr(USI_ADDR_STATUS, 8'h01, 1'b1);
      wr(USI_ADDR_DEVADDR, 8'h20, 1'b1);
      wr(USI_ADDR_STATUS, 8'h00, 1'b1);
      i_sie.send(EV_ACK);
      chk({1'b0, dev_addr}, 8'h0a);
   endtask : t_address

   task automatic t_flags;
      i_sie.send(EV_F0 | EV_CRC);
      rd_chk(USI_ADDR_STATUS, 8'h62);
      wr(USI_ADDR_STATUS, 8'h00, 1'b1);
      rd_chk(USI_ADDR_STATUS, 8'h40);
      wr(USI_ADDR_STATUS, 8'h26, 1'b1);
      rd_chk(USI_ADDR_STATUS, 8'h40);
      i_sie.send(EV_OUTNZ);
      rd_chk(USI_ADDR_STATUS, 8'h44);
      i_sie.send(EV_SETUP);
      rd_chk(USI_ADDR_STATUS, 8'h40);
      i_sie.send(EV_IN);
      wr(USI_ADDR_STATUS, 8'h00, 1'b1);
      rd_chk(USI_ADDR_STATUS, 8'h48);
      i_sie.send(EV_OUTNZ);
      rd_chk(USI_ADDR_STATUS, 8'h44);
      wr(USI_ADDR_STATUS, 8'h00, 1'b1);
      rd_chk(USI_ADDR_STATUS, 8'h40);
   endtask : t_flags

   task automatic t_nak;
      i_sie.send(EV_NAK);
      chk({7'h00, nak_irq}, 8'h01);
      @(negedge core_clk);
      chk({7'h00, nak_irq}, 8'h00);
      rd_chk(USI_ADDR_STATUS, 8'h50);
      // Bit 4 is read-only, so this write only sets the mask
      wr(USI_ADDR_STATUS, 8'h80, 1'b1);
      i_sie.send(EV_NAK);
      chk({7'h00, nak_irq}, 8'h00);
      rd_chk(USI_ADDR_STATUS, 8'hd0);
      i_sie.send(EV_SETUP);
      rd_chk(USI_ADDR_STATUS, 8'hc0);
      wr(USI_ADDR_STATUS, 8'h00, 1'b1);
   endtask : t_nak

   task automatic t_access_eot;
      i_sie.send(EV_EP1);
      rd_chk(USI_ADDR_ACCESS, 8'h02);
      rd_chk(USI_ADDR_ACCESS, 8'h00);
      i_sie.set_eot(1'b0);
      rd_chk(USI_ADDR_STATUS, 8'h00);
      wr(USI_ADDR_STATUS, 8'h40, 1'b1);
      rd_chk(USI_ADDR_STATUS, 8'h00);
      i_sie.set_eot(1'b1);
      rd_chk(USI_ADDR_STATUS, 8'h40);
   endtask : t_access_eot

   // Second reset mid-run must restore the address, direction, halt and status registers
   task automatic t_rerun_reset;
      @(negedge core_clk);
      rst_n <= 1'b0;
      @(negedge core_clk);
      rst_n <= 1'b1;
      chk({1'b0, dev_addr}, 8'h00);
      chk({6'h00, ep_dir_in}, 8'h03);
      chk({6'h00, ep_halt}, 8'h00);
      rd_chk(USI_ADDR_DEVADDR, 8'h00);
      rd_chk(USI_ADDR_STATUS, 8'h40);
   endtask : t_rerun_reset

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   // Whole run is about 130 cycles; far longer means a hang
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end

   initial begin
      repeat (4) @(negedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_bitmaps();
      t_address();
      t_flags();
      t_nak();
      t_access_eot();
      t_rerun_reset();
      print_verdict();
   end
endmodule : tb_usi_regs
